// ===== ils_datapath.sv
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ils_datapath (
    input  wire logic                 sys_clk_i,
    input  wire logic                 arst_n_i,
    input  wire ils_pkg::ils_issue_t  issue_i,
    output logic                      issue_ready_o,
    output ils_pkg::ils_result_t      result_o,
    output logic      [3:0]           icc_o,
    input  wire logic [3:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        ils_pkg::ils_result_t   result;
        logic [3:0]             icc;
        logic                   enable;
        logic [31:0]            last;
        logic [31:0]            count;
        ils_pkg::ils_bus_state_t bus;
        logic [31:0]            readdata;
    } ils_state_t;

    ils_state_t state_q;
    ils_state_t state_d;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] ils_sign_ext(input logic [31:0] instr);
        ils_sign_ext = {{19{instr[ils_pkg::SIMM_MSB]}}, instr[ils_pkg::SIMM_MSB:0]};
    endfunction : ils_sign_ext

    function automatic logic [31:0] ils_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  lanes);
        logic [31:0] merged;
        merged = old_val;
        for (int b = 0; b < 4; b++) begin
            if (lanes[b]) begin
                merged[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        ils_merge = merged;
    endfunction : ils_merge

    // ****************************************************************
    // field extraction
    // ****************************************************************
    logic [31:0]              instr;
    logic [1:0]               major;
    logic [2:0]               minor_opcode_field;
    logic [5:0]               operation_select_field;
    logic [5:0]               base_op;
    logic                     imm_sel;
    logic [4:0]               dest_index;
    logic [4:0]               first_source_index;
    logic [4:0]               second_source_index;
    logic [31:0]              signed_short_immediate;
    logic [21:0]              upper_immediate_field;
    logic [31:0]              operand_b;
    logic [4:0]               shift_amount;
    logic [31:0]              shifted;
    ils_pkg::ils_shift_kind_t shift_kind;

    assign instr                  = issue_i.instr;
    assign major                  = instr[31:30];
    assign minor_opcode_field     = instr[ils_pkg::MINOR_MSB:ils_pkg::MINOR_LSB];
    assign operation_select_field = instr[ils_pkg::OPSEL_MSB:ils_pkg::OPSEL_LSB];
    assign dest_index             = instr[ils_pkg::DEST_MSB:ils_pkg::DEST_LSB];
    assign first_source_index     = instr[ils_pkg::SRC1_MSB:ils_pkg::SRC1_LSB];
    assign second_source_index    = instr[ils_pkg::SRC2_MSB:ils_pkg::SRC2_LSB];
    assign imm_sel                = instr[ils_pkg::IMM_SEL_BIT];
    assign signed_short_immediate = ils_sign_ext(instr);
    assign upper_immediate_field  = instr[ils_pkg::UPPER_MSB:0];
    // clearing the cc bit lets one compare serve both variants
    assign base_op                = operation_select_field & ~6'h10;

    // register indices are resolved by the register file before issue
    assign operand_b    = imm_sel ? signed_short_immediate : issue_i.second_source_data;
    // only the low five bits count; bits 5..12 of an immediate shift are trusted zero
    assign shift_amount = imm_sel ? second_source_index : issue_i.second_source_data[4:0];

    always_comb begin
        unique case (operation_select_field)
            ils_pkg::OP_SLL: shift_kind = ils_pkg::SHIFT_LEFT;
            ils_pkg::OP_SRL: shift_kind = ils_pkg::SHIFT_RIGHT;
            default:         shift_kind = ils_pkg::SHIFT_ARITH;
        endcase
    end

    // a zero amount shifts by nothing, so the first operand comes through as is
    ils_shifter u_shifter (
        .value_i   (issue_i.first_source_data),
        .amount_i  (shift_amount),
        .kind_i    (shift_kind),
        .shifted_o (shifted)
    );

    // ****************************************************************
    // execute
    // ****************************************************************
    logic        is_logic;
    logic        is_shift;
    logic        is_upper;
    logic        is_cc;
    logic [31:0] logic_res;
    logic [31:0] exec_res;

    always_comb begin
        is_logic  = 1'b0;
        logic_res = 32'h0000_0000;
        unique case (base_op)
            ils_pkg::OP_AND: begin
                is_logic  = 1'b1;
                logic_res = issue_i.first_source_data & operand_b;
            end
            ils_pkg::OP_OR: begin
                is_logic  = 1'b1;
                logic_res = issue_i.first_source_data | operand_b;
            end
            ils_pkg::OP_XOR: begin
                is_logic  = 1'b1;
                logic_res = issue_i.first_source_data ^ operand_b;
            end
            ils_pkg::OP_ANDN: begin
                is_logic  = 1'b1;
                logic_res = issue_i.first_source_data & ~operand_b;
            end
            ils_pkg::OP_ORN: begin
                is_logic  = 1'b1;
                logic_res = issue_i.first_source_data | ~operand_b;
            end
            ils_pkg::OP_XNOR: begin
                is_logic  = 1'b1;
                logic_res = ~(issue_i.first_source_data ^ operand_b);
            end
            default: begin
                is_logic  = 1'b0;
                logic_res = 32'h0000_0000;
            end
        endcase
    end

    assign is_shift = (major == ils_pkg::MAJOR_ARITH) &&
                      (operation_select_field == ils_pkg::OP_SLL ||
                       operation_select_field == ils_pkg::OP_SRL ||
                       operation_select_field == ils_pkg::OP_SRA);
    assign is_upper = (major == ils_pkg::MAJOR_UPPER) &&
                      (minor_opcode_field == ils_pkg::MINOR_UPPER);
    assign is_cc    = operation_select_field[ils_pkg::CC_VARIANT_BIT];
    assign exec_res = is_upper ? {upper_immediate_field, {ils_pkg::LOW_CLEAR_BITS{1'b0}}}
                    : is_shift ? shifted
                    : logic_res;

    // ****************************************************************
    // next state
    // ****************************************************************
    logic issue_take;
    logic logic_take;
    logic bus_req;
    logic bus_done;

    assign issue_take = issue_i.valid && state_q.enable;
    assign logic_take = issue_take && is_logic && (major == ils_pkg::MAJOR_ARITH);
    assign bus_req    = avs_read_i || avs_write_i;
    assign bus_done   = bus_req && (state_q.bus == ils_pkg::BUS_ACK);

    always_comb begin
        state_d        = state_q;
        state_d.result = '0;
        // software writes first so an instruction in the same cycle wins
        if (bus_done && avs_write_i) begin
            unique case (avs_address_i)
                ils_pkg::REG_CTRL: begin
                    if (avs_byteenable_i[0]) begin
                        state_d.enable = avs_writedata_i[0];
                    end
                end
                ils_pkg::REG_ICC: begin
                    if (avs_byteenable_i[0]) begin
                        state_d.icc = avs_writedata_i[3:0];
                    end
                end
                ils_pkg::REG_COUNT: state_d.count = ils_merge(state_q.count, avs_writedata_i, avs_byteenable_i);
                default:            state_d.count = state_q.count;
            endcase
        end
        // no trap path exists: unknown encodings simply write nothing
        if (issue_take && (logic_take || is_shift || is_upper)) begin
            state_d.result.valid      = 1'b1;
            state_d.result.dest_index = dest_index;
            state_d.result.dest_data  = exec_res;
            state_d.result.nop        = is_upper && (dest_index == 5'h00) &&
                                        (upper_immediate_field == 22'h00_0000);
            state_d.result.dest_write = !state_d.result.nop;
            state_d.last              = exec_res;
            state_d.count             = state_q.count + 32'h0000_0001;
            if (logic_take && is_cc) begin
                state_d.result.icc_write = 1'b1;
                state_d.icc = {exec_res[31], exec_res == 32'h0000_0000, 2'h0};
            end
            state_d.result.icc = state_d.icc;
        end else begin
            state_d.result.icc = state_q.icc;
        end
        // bus answers one cycle after the request, then releases
        state_d.bus      = (bus_req && state_q.bus == ils_pkg::BUS_IDLE) ? ils_pkg::BUS_ACK : ils_pkg::BUS_IDLE;
        state_d.readdata = 32'h0000_0000;
        if (bus_req && avs_read_i && state_q.bus == ils_pkg::BUS_IDLE) begin
            unique case (avs_address_i)
                ils_pkg::REG_CTRL:  state_d.readdata = {31'h0000_0000, state_q.enable};
                ils_pkg::REG_ICC:   state_d.readdata = {28'h000_0000, state_q.icc};
                ils_pkg::REG_LAST:  state_d.readdata = state_q.last;
                ils_pkg::REG_COUNT: state_d.readdata = state_q.count;
                default:            state_d.readdata = 32'h0000_0000;
            endcase
        end else if (state_q.bus == ils_pkg::BUS_ACK) begin
            state_d.readdata = state_q.readdata;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q          <= '0;
            state_q.enable   <= ils_pkg::CTRL_RESET;
            state_q.icc      <= ils_pkg::ICC_RESET;
            state_q.last     <= ils_pkg::LAST_RESET;
            state_q.count    <= ils_pkg::COUNT_RESET;
            state_q.bus      <= ils_pkg::BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // the datapath never stalls; ready simply mirrors the enable bit
    assign issue_ready_o     = state_q.enable;
    assign result_o          = state_q.result;
    assign icc_o             = state_q.icc;
    assign avs_readdata_o    = state_q.readdata;
    assign avs_waitrequest_o = (state_q.bus == ils_pkg::BUS_IDLE);

endmodule : ils_datapath

`default_nettype wire

// ===== ils_shifter.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// shared constants and carriers
// ****************************************************************
package ils_pkg;
    localparam logic [1:0] MAJOR_ARITH    = 2'h2;
    localparam logic [1:0] MAJOR_UPPER    = 2'h0;
    localparam logic [2:0] MINOR_UPPER    = 3'h4;
    localparam logic [5:0] OP_AND         = 6'h01;
    localparam logic [5:0] OP_OR          = 6'h02;
    localparam logic [5:0] OP_XOR         = 6'h03;
    localparam logic [5:0] OP_ANDN        = 6'h05;
    localparam logic [5:0] OP_ORN         = 6'h06;
    localparam logic [5:0] OP_XNOR        = 6'h07;
    localparam logic [5:0] OP_SLL         = 6'h25;
    localparam logic [5:0] OP_SRL         = 6'h26;
    localparam logic [5:0] OP_SRA         = 6'h27;
    localparam int         CC_VARIANT_BIT = 4;
    localparam int         IMM_SEL_BIT    = 13;
    localparam int         DEST_MSB       = 29;
    localparam int         DEST_LSB       = 25;
    localparam int         OPSEL_MSB      = 24;
    localparam int         OPSEL_LSB      = 19;
    localparam int         SRC1_MSB       = 18;
    localparam int         SRC1_LSB       = 14;
    localparam int         SRC2_MSB       = 4;
    localparam int         SRC2_LSB       = 0;
    localparam int         SIMM_MSB       = 12;
    localparam int         UPPER_MSB      = 21;
    localparam int         MINOR_MSB      = 24;
    localparam int         MINOR_LSB      = 22;
    localparam int         LOW_CLEAR_BITS = 10;
    // register map, byte addresses
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_ICC        = 4'h4;
    localparam logic [3:0]  REG_LAST       = 4'h8;
    localparam logic [3:0]  REG_COUNT      = 4'hC;
    localparam logic        CTRL_RESET     = 1'h1;
    localparam logic [3:0]  ICC_RESET      = 4'h0;
    localparam logic [31:0] LAST_RESET     = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;

    typedef enum logic [1:0] {
        SHIFT_LEFT  = 2'h0,
        SHIFT_RIGHT = 2'h1,
        SHIFT_ARITH = 2'h3
    } ils_shift_kind_t;

    typedef enum logic {
        BUS_IDLE = 1'h0,
        BUS_ACK  = 1'h1
    } ils_bus_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] first_source_data;
        logic [31:0] second_source_data;
    } ils_issue_t;

    // condition codes in order negative, zero, overflow, carry
    typedef struct packed {
        logic        valid;
        logic        dest_write;
        logic [4:0]  dest_index;
        logic [31:0] dest_data;
        logic        icc_write;
        logic [3:0]  icc;
        logic        nop;
    } ils_result_t;
endpackage : ils_pkg

// ****************************************************************
// barrel shifter
// ****************************************************************
module ils_shifter (
    input  wire logic [31:0]            value_i,
    input  wire logic [4:0]             amount_i,
    input  wire ils_pkg::ils_shift_kind_t kind_i,
    output logic      [31:0]            shifted_o
);
    always_comb begin
        unique case (kind_i)
            ils_pkg::SHIFT_LEFT:  shifted_o = value_i << amount_i;
            ils_pkg::SHIFT_RIGHT: shifted_o = value_i >> amount_i;
            ils_pkg::SHIFT_ARITH: shifted_o = 32'($signed(value_i) >>> amount_i);
            default:              shifted_o = value_i;
        endcase
    end
endmodule : ils_shifter

`default_nettype wire

// ===== ils_issue_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// decoder and register file stand-in
// ****************************************************************
module ils_issue_model (
    input  wire logic           sys_clk_i,
    input  wire logic           valid_i,
    input  wire logic [31:0]    instr_i,
    input  wire logic [31:0]    first_i,
    input  wire logic [31:0]    second_i,
    output ils_pkg::ils_issue_t issue_o
);
    logic [31:0] junk_q = 32'h5A5A_A5A5;
    logic        imm_shift;

    // idle lines churn every cycle so a stale operand never passes for a live one
    always @(posedge sys_clk_i) begin
        junk_q <= ~junk_q;
    end

    assign imm_shift = instr_i[13] && instr_i[31:30] == ils_pkg::MAJOR_ARITH &&
                       instr_i[24:19] inside {ils_pkg::OP_SLL, ils_pkg::OP_SRL, ils_pkg::OP_SRA};

    always_comb begin
        issue_o.valid              = valid_i;
        issue_o.instr              = valid_i ? instr_i : junk_q;
        if (imm_shift) begin
            issue_o.instr[12:5] = 8'h00;
        end
        issue_o.first_source_data  = valid_i ? first_i : junk_q;
        issue_o.second_source_data = valid_i ? second_i : ~junk_q;
    end
endmodule : ils_issue_model

`default_nettype wire

// ===== ils_datapath_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// port checker
// ****************************************************************
module ils_datapath_monitor (
    input wire logic                 sys_clk_i,
    input wire logic                 arst_n_i,
    input wire ils_pkg::ils_issue_t  issue_i,
    input wire logic                 issue_ready_o,
    input wire ils_pkg::ils_result_t result_o,
    input wire logic [3:0]           icc_o,
    input wire logic [3:0]           avs_address_i,
    input wire logic                 avs_read_i,
    input wire logic                 avs_write_i,
    input wire logic [31:0]          avs_writedata_i,
    input wire logic [3:0]           avs_byteenable_i,
    input wire logic [31:0]          avs_readdata_o,
    input wire logic                 avs_waitrequest_o
);
    logic [31:0] ins;
    logic [31:0] opnd_b;
    logic [31:0] a;
    logic [4:0]  amt;
    logic        tk;
    logic        lg;
    logic        sh;
    logic        up;

    assign ins = issue_i.instr;
    assign a   = issue_i.first_source_data;
    assign tk  = issue_i.valid && issue_ready_o;
    assign lg  = tk && ins[31:30] == ils_pkg::MAJOR_ARITH && !ins[24] && !ins[22] && ins[21:19] != 3'h0 &&
                 ins[21:19] != 3'h4;
    assign sh  = tk && ins[31:30] == ils_pkg::MAJOR_ARITH &&
                 ins[24:19] inside {ils_pkg::OP_SLL, ils_pkg::OP_SRL, ils_pkg::OP_SRA};
    assign up  = tk && ins[31:30] == ils_pkg::MAJOR_UPPER && ins[24:22] == ils_pkg::MINOR_UPPER;
    assign opnd_b = ins[13] ? {{19{ins[12]}}, ins[12:0]} : issue_i.second_source_data;
    assign amt = ins[13] ? ins[4:0] : issue_i.second_source_data[4:0];

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_NO_SPURIOUS: assert property (!tk |=> !result_o.valid)
        else $error("result without an accepted issue");
    AST_LOGIC_PLAIN: assert property (lg && !ins[23] |=> result_o.valid && result_o.dest_write &&
        !result_o.icc_write && result_o.dest_index == $past(ins[29:25]))
        else $error("plain logical result wrong");
    AST_LOGIC_CC: assert property (lg && ins[23] |=> result_o.icc_write && icc_o == result_o.icc &&
        result_o.icc == {result_o.dest_data[31], result_o.dest_data == 32'h0, 2'h0})
        else $error("condition codes wrong");
    AST_ANDN: assert property (lg && ins[21:19] == 3'h5 |=> result_o.dest_data == ($past(a) & ~$past(opnd_b)))
        else $error("and-not result wrong");
    AST_XNOR: assert property (lg && ins[21:19] == 3'h7 |=> result_o.dest_data == ~($past(a) ^ $past(opnd_b)))
        else $error("exclusive-nor result wrong");
    AST_SHIFT_CC: assert property (sh |=> result_o.valid && !result_o.icc_write && icc_o == $past(icc_o))
        else $error("shift touched condition codes");
    AST_SRA: assert property (sh && ins[21:19] == 3'h7 |=>
        result_o.dest_data == $unsigned($signed($past(a)) >>> $past(amt)))
        else $error("arithmetic right shift wrong");
    AST_ZERO_SHIFT: assert property (sh && amt == 5'h00 |=> result_o.dest_data == $past(a))
        else $error("zero shift altered operand");
    AST_UPPER: assert property (up |=> result_o.valid && !result_o.icc_write &&
        result_o.dest_data == {$past(ins[21:0]), 10'h000})
        else $error("load-upper result wrong");
    AST_NOP: assert property (up && ins[29:25] == 5'h00 && ins[21:0] == 22'h0 |=>
        result_o.nop && !result_o.dest_write)
        else $error("no-operation wrote a register");

    cover property (lg && ins[23]);
    cover property (sh && amt == 5'h00);
    cover property (up && ins[29:25] == 5'h00 && ins[21:0] == 22'h0);
endmodule : ils_datapath_monitor

bind ils_datapath ils_datapath_monitor i_ils_datapath_monitor (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .issue_i(issue_i), .issue_ready_o(issue_ready_o),
    .result_o(result_o), .icc_o(icc_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

`default_nettype wire

// ===== ils_datapath_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ils_datapath_tb;
    typedef struct packed {
        logic [31:0] ins;
        logic [31:0] b;
        logic [31:0] dat;
        logic        iccw;
        logic [3:0]  icc;
    } ils_row_t;
    localparam logic [31:0] OPA = 32'hF0F0_00FF;
    localparam logic [31:0] OPB = 32'h0FF0_0F0F;
    logic                sys_clk = 1'b0;
    logic                arst_n  = 1'b0;
    logic                vi      = 1'b0;
    logic [31:0]         ins     = 32'h0;
    logic [31:0]         b       = 32'h0;
    logic [3:0]          adr     = 4'h0;
    logic                rd_s    = 1'b0;
    logic                wr_s    = 1'b0;
    logic [31:0]         wd      = 32'h0;
    logic [31:0]         rdata;
    ils_pkg::ils_issue_t issue;
    ils_pkg::ils_result_t res;
    logic                rdy;
    logic [3:0]          icc;
    logic [31:0]         rdat;
    logic                wreq;
    int                  num_errors = 0;
    int                  num_checks = 0;
    int                  cycles     = 0;
    ils_row_t            rows[$];

    always #2.5 sys_clk = ~sys_clk;

    ils_issue_model i_ils_issue_model (.sys_clk_i(sys_clk), .valid_i(vi), .instr_i(ins), .first_i(OPA),
        .second_i(b), .issue_o(issue));
    ils_datapath i_ils_datapath (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .issue_i(issue), .issue_ready_o(rdy),
        .result_o(res), .icc_o(icc), .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));

    function automatic logic [31:0] f3(input logic [5:0] op, input logic imm, input logic [12:0] low);
        return {ils_pkg::MAJOR_ARITH, 5'h00, op, 5'h00, imm, low};
    endfunction : f3

    function automatic logic [31:0] hi(input logic [21:0] v);
        return {ils_pkg::MAJOR_UPPER, 5'h00, ils_pkg::MINOR_UPPER, v};
    endfunction : hi

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic add(input logic [31:0] i, input logic [31:0] bv, input logic [31:0] d, input logic w,
                       input logic [3:0] c);
        rows.push_back('{i, bv, d, w, c});
    endtask : add

    // one request held until waitrequest is sampled low; no fixed latency assumed
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        adr  <= a;
        wr_s <= w;
        rd_s <= !w;
        wd   <= d;
        do @(posedge sys_clk); while (wreq !== 1'b0);
        q = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask : bus

    task automatic issue_one(input logic [31:0] i);
        @(posedge sys_clk);
        vi  <= 1'b1;
        ins <= i;
        @(posedge sys_clk);
        vi  <= 1'b0;
        #1;
    endtask : issue_one

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // ****************************************************************
    // watchdog
    // ****************************************************************
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            num_errors++;
            summarize();
        end
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        ils_row_t r;
        add(f3(ils_pkg::OP_AND, 1'b0, 13'h0), OPB, 32'h00F0_000F, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_OR, 1'b0, 13'h0), OPB, 32'hFFF0_0FFF, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_XOR, 1'b0, 13'h0), OPB, 32'hFF00_0FF0, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_ANDN, 1'b0, 13'h0), OPB, 32'hF000_00F0, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_ORN, 1'b0, 13'h0), OPB, 32'hF0FF_F0FF, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_XNOR, 1'b0, 13'h0), OPB, 32'h00FF_F00F, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_OR | 6'h10, 1'b0, 13'h0), OPB, 32'hFFF0_0FFF, 1'b1, 4'h8);
        add(f3(ils_pkg::OP_SLL, 1'b0, 13'h0), 32'hFFFF_FFE4, 32'h0F00_0FF0, 1'b0, 4'h8);
        add(hi(22'h3F_FFFF), OPB, 32'hFFFF_FC00, 1'b0, 4'h8);
        add(f3(ils_pkg::OP_AND | 6'h10, 1'b0, 13'h0), 32'h0, 32'h0, 1'b1, 4'h4);
        add(f3(ils_pkg::OP_XOR | 6'h10, 1'b0, 13'h0), OPB, 32'hFF00_0FF0, 1'b1, 4'h8);
        add(f3(ils_pkg::OP_ANDN | 6'h10, 1'b0, 13'h0), OPB, 32'hF000_00F0, 1'b1, 4'h8);
        add(f3(ils_pkg::OP_ORN | 6'h10, 1'b0, 13'h0), OPB, 32'hF0FF_F0FF, 1'b1, 4'h8);
        add(f3(ils_pkg::OP_XNOR | 6'h10, 1'b0, 13'h0), OPB, 32'h00FF_F00F, 1'b1, 4'h0);
        add(f3(ils_pkg::OP_AND | 6'h10, 1'b0, 13'h0), OPB, 32'h00F0_000F, 1'b1, 4'h0);
        add(f3(ils_pkg::OP_AND, 1'b1, 13'h1000), OPB, 32'hF0F0_0000, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_OR, 1'b1, 13'h0FFF), OPB, 32'hF0F0_0FFF, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_SRL, 1'b1, 13'h0008), OPB, 32'h00F0_F000, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_SRA, 1'b1, 13'h0008), OPB, 32'hFFF0_F000, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_SRA, 1'b0, 13'h0), 32'hFFFF_FFE0, OPA, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_SRL, 1'b0, 13'h0), 32'h0000_001F, 32'h0000_0001, 1'b0, 4'h0);
        add(f3(ils_pkg::OP_SLL, 1'b0, 13'h0), 32'h0000_001F, 32'h8000_0000, 1'b0, 4'h0);
        add(hi(22'h01_2345), OPB, 32'h048D_1400, 1'b0, 4'h0);
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        // back to back: row i is driven while the result of row i-1 is checked
        for (int i = 0; i <= rows.size(); i++) begin
            @(posedge sys_clk);
            vi <= (i < rows.size());
            if (i < rows.size()) begin
                ins <= rows[i].ins | (32'(i + 1) << 25);
                b   <= rows[i].b;
            end
            if (i > 0) begin
                #1;
                r = rows[i - 1];
                chk(32'({res.valid, res.dest_write, res.icc_write}), 32'({2'b11, r.iccw}));
                chk(32'(res.dest_index), 32'(i));
                chk(res.dest_data, r.dat);
                chk(32'(icc), 32'(r.icc));
            end
        end
        $display("test table done");
        issue_one(hi(22'h0));
        chk(32'({res.valid, res.dest_write, res.nop}), 32'h5);
        issue_one(f3(6'h00, 1'b0, 13'h0));
        chk(32'(res.valid), 32'h0);
        $display("test nop done");
        bus(1'b0, 4'h2, 32'h0, rdata);
        chk(rdata, 32'h0);
        bus(1'b1, ils_pkg::REG_CTRL, 32'h0, rdata);
        issue_one(f3(ils_pkg::OP_OR, 1'b0, 13'h0));
        chk(32'({rdy, res.valid}), 32'h0);
        bus(1'b1, ils_pkg::REG_CTRL, 32'h1, rdata);
        bus(1'b1, ils_pkg::REG_ICC, 32'hA, rdata);
        bus(1'b0, ils_pkg::REG_ICC, 32'h0, rdata);
        chk(rdata, 32'hA);
        issue_one(f3(ils_pkg::OP_SRA, 1'b1, 13'h0));
        chk(res.dest_data, OPA);
        chk(32'(icc), 32'hA);
        bus(1'b0, ils_pkg::REG_LAST, 32'h0, rdata);
        chk(rdata, OPA);
        $display("test bus done");
        @(posedge sys_clk);
        arst_n <= 1'b0;
        #1;
        chk(32'({res.valid, wreq, rdy, icc}), 32'h30);
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        issue_one(f3(ils_pkg::OP_ANDN | 6'h10, 1'b0, 13'h0));
        chk(32'(icc), 32'h8);
        $display("test reset done");
        summarize();
    end
endmodule : ils_datapath_tb

`default_nettype wire
